// [hw/fast_ethernet_pcs_receiver.sv]
// Nibble buffer and 100Base-X receive coding path with link monitor.

// Synchronous FIFO with valid and ready on both sides.
module pcs_nibble_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             ref_clk_i,
    input  wire logic             nrst_i,
    // Filling side.
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side.
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    wire              push;
    wire              pop;

    // Handshakes and flags.
    assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem_ff[rd_ff];

    // Storage array.
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    // Pointers and fill count.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= push ? AW'(wr_ff + 1'b1) : wr_ff;
            rd_ff  <= pop ? AW'(rd_ff + 1'b1) : rd_ff;
            cnt_ff <= (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
        end
    end
endmodule

// Behaviour
// - Line bits turn NRZI to NRZ unaligned.
// - Lock descrambler after 40 idle bits.
// - Locked, XOR each bit with key stream.
// - Hold timer restarts on enough idles.
// - Timer expiry drops lock and reacquires.
// - Find J/K, then fix 5-bit boundary.
// - Table decode; J/K becomes preamble nibbles.
// - Translation stops at T/R delimiter.
// - Bit 0 of data is nibble LSB.
// - Data valid rises with first preamble nibble.
// - Valid drops on T/R, link fail, no signal.
// - Error flags invalid code words during valid.
// - No reliable link halts receive.
// - Link bit muxes 100M and 10M status.
// - Energy and lock 500 us give ready; wait negotiation.
// - Negotiation off: ready goes straight up.
// - Carrier on two split zeros in ten.
// - Switch mode counts transmit; repeater receive only.
// - Carrier drops on idle pair, encloses valid.
// - Bad start: error with nibble 1110.
// - Bad start ends after two idle groups.
module fast_ethernet_pcs_receiver #(
    parameter int HOLD_CYCLES  = pcs_rx_pkg::HOLD_CYCLES,
    parameter int READY_CYCLES = pcs_rx_pkg::READY_CYCLES
) (
    // Clock and reset.
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    // Recovered line data and front-end status.
    input  wire logic       rx_line_i,
    input  wire logic       signal_detect_i,
    // Mode and neighbour status.
    input  wire logic       repeater_mode_i,
    input  wire logic       tx_active_i,
    input  wire logic       an_enable_i,
    input  wire logic       an_link_ok_i,
    input  wire logic       speed100_i,
    input  wire logic       link10_i,
    // MII receive bus.
    input  wire logic       mii_ready_i,
    output logic [3:0]      rxd_o,
    output logic            rx_dv_o,
    output logic            rx_er_o,
    output logic            crs_o,
    // Link and status outputs.
    output logic            link_up_o,
    output logic            link_status_o,
    output logic            link_activity_output_o,
    output logic            scr_locked_o,
    output logic            rx_fifo_ready_o
);
    localparam int CW = $clog2(HOLD_CYCLES + READY_CYCLES + 1);
    localparam int L = pcs_rx_pkg::LFSR_LEN;

    // 4B5B lookup: returns {valid, nibble}.
    function automatic logic [4:0] dec5(input logic [4:0] s);
        unique case (s)
            5'h1E: dec5 = 5'h10;
            5'h09: dec5 = 5'h11;
            5'h14: dec5 = 5'h12;
            5'h15: dec5 = 5'h13;
            5'h0A: dec5 = 5'h14;
            5'h0B: dec5 = 5'h15;
            5'h0E: dec5 = 5'h16;
            5'h0F: dec5 = 5'h17;
            5'h12: dec5 = 5'h18;
            5'h13: dec5 = 5'h19;
            5'h16: dec5 = 5'h1A;
            5'h17: dec5 = 5'h1B;
            5'h1A: dec5 = 5'h1C;
            5'h1B: dec5 = 5'h1D;
            5'h1C: dec5 = 5'h1E;
            5'h1D: dec5 = 5'h1F;
            default: dec5 = 5'h00;
        endcase
    endfunction

    // True when a window holds two zeros that are not neighbours.
    function automatic logic split_zeros(input logic [9:0] w);
        split_zeros = 1'b0;
        for (int i = 0; i < 10; i++) begin
            for (int j = i + 2; j < 10; j++) begin
                if (!w[i] && !w[j]) begin
                    split_zeros = 1'b1;
                end
            end
        end
    endfunction

    // Bit and nibble rate enables.
    logic [0:0] bdiv_ff;
    logic [3:0] ndiv_ff;
    wire        bit_en = (bdiv_ff == 1'h0);
    wire        nib_en = (ndiv_ff == 4'h0);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bdiv_ff <= '0;
            ndiv_ff <= '0;
        end else begin
            bdiv_ff <= 1'(bdiv_ff + 1'b1);
            ndiv_ff <= (ndiv_ff == 4'(pcs_rx_pkg::NIB_DIV - 1)) ? 4'h0 : 4'(ndiv_ff + 1'b1);
        end
    end

    // Line decoding and descrambler.
    logic          line_ff;
    logic [L-1:0]  guess_ff;
    logic [L-1:0]  lfsr_ff;
    logic          locked_ff;
    logic [5:0]    run_ff;
    logic [4:0]    ones_ff;
    logic [CW-1:0] hold_ff;
    wire           nrz      = rx_line_i ^ line_ff;
    wire           kguess   = ~nrz;
    wire           kpred    = guess_ff[pcs_rx_pkg::LFSR_TAP_A] ^ guess_ff[pcs_rx_pkg::LFSR_TAP_B];
    wire           key      = lfsr_ff[pcs_rx_pkg::LFSR_TAP_A] ^
                              lfsr_ff[pcs_rx_pkg::LFSR_TAP_B];
    wire           plain    = nrz ^ key;
    wire           lock_hit = (run_ff == 6'(pcs_rx_pkg::IDLE_LOCK_BITS - 1)) && (kguess == kpred);
    wire           rearm    = plain && (ones_ff == 5'(pcs_rx_pkg::IDLE_REARM_BITS - 1));
    wire           expire   = (hold_ff == CW'(HOLD_CYCLES - 1));
    wire           drop     = expire || !signal_detect_i;

    // Line history and key guesses; the guess register trains the lock search.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_ff  <= 1'b0;
            guess_ff <= '0;
            run_ff   <= '0;
        end else if (bit_en) begin
            line_ff  <= rx_line_i;
            guess_ff <= {guess_ff[L-2:0], kguess};
            run_ff   <= (locked_ff || kguess != kpred) ? 6'h00 :
                        (lock_hit ? run_ff : 6'(run_ff + 1'b1));
        end
    end

    // Lock, key stream and hold timer.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            locked_ff <= 1'b0;
            lfsr_ff   <= '0;
            ones_ff   <= '0;
            hold_ff   <= '0;
        end else if (drop && locked_ff) begin
            locked_ff <= 1'b0;
            hold_ff   <= '0;
            ones_ff   <= '0;
        end else if (locked_ff) begin
            hold_ff <= (bit_en && rearm) ? CW'(0) : CW'(hold_ff + 1'b1);
            if (bit_en) begin
                lfsr_ff <= {lfsr_ff[L-2:0], key};
                ones_ff <= (!plain || rearm) ? 5'h00 : 5'(ones_ff + 1'b1);
            end
        end else if (bit_en && lock_hit) begin
            locked_ff <= 1'b1;
            lfsr_ff   <= {guess_ff[L-2:0], kguess};
            hold_ff   <= '0;
        end
    end

    // Link monitor.
    pcs_rx_pkg::link_state_t lk_ff;
    pcs_rx_pkg::link_state_t nxt_lk;
    logic [CW-1:0]           rdy_ff;
    wire           link_ok = signal_detect_i && locked_ff;
    wire           link_up = (lk_ff == pcs_rx_pkg::LK_UP);

    always_comb begin
        nxt_lk = lk_ff;
        unique case (lk_ff)
            pcs_rx_pkg::LK_DOWN:  nxt_lk = link_ok ? pcs_rx_pkg::LK_WAIT : lk_ff;
            pcs_rx_pkg::LK_WAIT:  nxt_lk = (rdy_ff == CW'(READY_CYCLES - 1)) ?
                                           pcs_rx_pkg::LK_READY : lk_ff;
            pcs_rx_pkg::LK_READY: nxt_lk = (!an_enable_i || an_link_ok_i) ?
                                           pcs_rx_pkg::LK_UP : lk_ff;
            pcs_rx_pkg::LK_UP:    nxt_lk = lk_ff;
        endcase
        if (!link_ok) begin
            nxt_lk = pcs_rx_pkg::LK_DOWN;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_ff  <= pcs_rx_pkg::LK_DOWN;
            rdy_ff <= '0;
        end else begin
            lk_ff  <= nxt_lk;
            rdy_ff <= (lk_ff == pcs_rx_pkg::LK_WAIT) ? CW'(rdy_ff + 1'b1) : CW'(0);
        end
    end

    // Alignment window, symbol phase and framing.
    logic [9:0]           sr_ff;
    logic [2:0]           ph_ff;
    logic [3:0]           wait_ff;
    logic                 tsym_ff;
    logic                 pend_ff;
    pcs_rx_pkg::rx_state_t st_ff;
    pcs_rx_pkg::rx_state_t nxt_st;
    pcs_rx_pkg::mii_beat_t beat;
    logic                 beat_vld;
    wire [9:0]            win   = {sr_ff[8:0], plain};
    wire                  jk    = (win == pcs_rx_pkg::JK_PAIR);
    wire                  idle2 = (win == pcs_rx_pkg::IDLE_PAIR);
    wire                  bound = (ph_ff == 3'h4);
    wire [4:0]            sym   = win[4:0];
    wire [4:0]            dec   = dec5(sym);
    wire                  carr  = split_zeros(win);

    always_comb begin
        nxt_st = st_ff;
        if (bit_en) begin
            unique case (st_ff)
                pcs_rx_pkg::RX_IDLE:    nxt_st = carr ? pcs_rx_pkg::RX_CARRIER : st_ff;
                pcs_rx_pkg::RX_CARRIER: nxt_st = jk ? pcs_rx_pkg::RX_DATA :
                    (wait_ff == 4'(pcs_rx_pkg::SSD_WAIT_BITS - 1)) ?
                    pcs_rx_pkg::RX_BAD : st_ff;
                pcs_rx_pkg::RX_DATA:    nxt_st = (bound && tsym_ff) ?
                                                 pcs_rx_pkg::RX_TAIL : st_ff;
                pcs_rx_pkg::RX_TAIL:    nxt_st = idle2 ? pcs_rx_pkg::RX_IDLE : st_ff;
                pcs_rx_pkg::RX_BAD:     nxt_st = (bound && idle2) ?
                                                 pcs_rx_pkg::RX_IDLE : st_ff;
            endcase
        end
        if (!link_up) begin
            nxt_st = pcs_rx_pkg::RX_IDLE;
        end
    end

    // Beat to store: preamble pair, decoded data, or bad-start filler.
    always_comb begin
        beat     = '0;
        beat_vld = 1'b0;
        if (pend_ff) begin
            beat     = '{dv: 1'b1, er: 1'b0, data: pcs_rx_pkg::NIB_PREAMBLE};
            beat_vld = 1'b1;
        end else if (bit_en && st_ff == pcs_rx_pkg::RX_CARRIER && jk) begin
            beat     = '{dv: 1'b1, er: 1'b0, data: pcs_rx_pkg::NIB_PREAMBLE};
            beat_vld = 1'b1;
        end else if (bit_en && bound && st_ff == pcs_rx_pkg::RX_DATA && !tsym_ff
                     && sym != pcs_rx_pkg::SYM_T) begin
            beat     = '{dv: 1'b1, er: !dec[4], data: dec[3:0]};
            beat_vld = 1'b1;
        end else if (bit_en && bound && st_ff == pcs_rx_pkg::RX_BAD && !idle2) begin
            beat     = '{dv: 1'b0, er: 1'b1, data: pcs_rx_pkg::NIB_BAD_SSD};
            beat_vld = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_ff   <= pcs_rx_pkg::RX_IDLE;
            sr_ff   <= '1;
            ph_ff   <= '0;
            wait_ff <= '0;
            tsym_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            pend_ff <= bit_en && st_ff == pcs_rx_pkg::RX_CARRIER && jk && link_up;
            if (bit_en) begin
                sr_ff   <= win;
                ph_ff   <= (jk || bound) ? 3'h0 : 3'(ph_ff + 1'b1);
                wait_ff <= (st_ff == pcs_rx_pkg::RX_CARRIER) ? 4'(wait_ff + 1'b1) : 4'h0;
                tsym_ff <= (st_ff == pcs_rx_pkg::RX_DATA) && (bound ?
                           (sym == pcs_rx_pkg::SYM_T) : tsym_ff);
            end
        end
    end

    // Nibble buffer between line timing and the MII.
    pcs_rx_pkg::mii_beat_t fifo_out;
    logic                  fifo_vld;
    wire                   take = nib_en && mii_ready_i;

    pcs_nibble_fifo #(
        .WIDTH ($bits(pcs_rx_pkg::mii_beat_t)),
        .DEPTH (pcs_rx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (beat_vld),
        .in_ready_o  (rx_fifo_ready_o),
        .in_data_i   (beat),
        .out_valid_o (fifo_vld),
        .out_ready_i (take),
        .out_data_o  (fifo_out)
    );

    // MII outputs.
    logic       dv_ff;
    logic       er_ff;
    logic [3:0] rxd_ff;
    logic       crs_ff;
    wire        rx_busy = (st_ff != pcs_rx_pkg::RX_IDLE);

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dv_ff  <= 1'b0;
            er_ff  <= 1'b0;
            rxd_ff <= '0;
            crs_ff <= 1'b0;
        end else begin
            if (!link_up) begin
                dv_ff <= 1'b0;
                er_ff <= 1'b0;
            end else if (take) begin
                dv_ff  <= fifo_vld && fifo_out.dv;
                er_ff  <= fifo_vld && fifo_out.er;
                rxd_ff <= fifo_vld ? fifo_out.data : 4'h0;
            end
            crs_ff <= link_up && (rx_busy || fifo_vld || dv_ff || er_ff);
        end
    end

    assign rxd_o   = rxd_ff;
    assign rx_dv_o = dv_ff;
    assign rx_er_o = er_ff;
    assign crs_o   = crs_ff || (!repeater_mode_i && tx_active_i);

    // Link reporting.
    assign link_up_o              = link_up;
    assign link_status_o          = speed100_i ? link_up : link10_i;
    assign link_activity_output_o = link_status_o;
    assign scr_locked_o           = locked_ff;
endmodule

// [hw/pcs_rx_pkg.sv]
// Constants and types shared by the 100Base-X receive path.
package pcs_rx_pkg;

    // Clock period of ref_clk_i in picoseconds (250 MHz).
    localparam int CLK_PERIOD_PS = 4000;

    // Line bits arrive every second clock (125 Mb/s).
    localparam int BIT_DIV = 2;
    // MII nibbles leave every tenth clock (25 MHz).
    localparam int NIB_DIV = 10;

    // Descrambler hold time in microseconds; longest time, rounds down.
    localparam int HOLD_TIME_US = 722;
    localparam int HOLD_CYCLES = (HOLD_TIME_US * 1000000) / CLK_PERIOD_PS;
    // Link-ready delay in microseconds; least time, rounds up.
    localparam int READY_TIME_US = 500;
    localparam int READY_CYCLES =
        (READY_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Idle bits needed to lock the descrambler.
    localparam int IDLE_LOCK_BITS = 40;
    // Consecutive plain idle bits that rearm the hold timer.
    localparam int IDLE_REARM_BITS = 30;
    // Bits allowed after carrier for a start delimiter to appear.
    localparam int SSD_WAIT_BITS = 10;

    // Descrambler length and feedback taps (x^11 + x^9 + 1).
    localparam int LFSR_LEN = 11;
    localparam int LFSR_TAP_A = 10;
    localparam int LFSR_TAP_B = 8;

    // Delimiter and special code groups, first line bit in the MSB.
    localparam logic [9:0] JK_PAIR = 10'h311;
    localparam logic [9:0] IDLE_PAIR = 10'h3FF;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;

    // Nibble values placed on the MII.
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_BAD_SSD = 4'hE;

    // Depth of the nibble buffer.
    localparam int FIFO_DEPTH = 16;

    // One MII receive beat.
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] data;
    } mii_beat_t;

    // Receive framing states.
    typedef enum logic [4:0] {
        RX_IDLE    = 5'h01,
        RX_CARRIER = 5'h02,
        RX_DATA    = 5'h04,
        RX_TAIL    = 5'h08,
        RX_BAD     = 5'h10
    } rx_state_t;

    // Link monitor states.
    typedef enum logic [3:0] {
        LK_DOWN  = 4'h1,
        LK_WAIT  = 4'h2,
        LK_READY = 4'h4,
        LK_UP    = 4'h8
    } link_state_t;

endpackage

// [verif/pcs_rx_sva.sv]
// Port-level checker for the 100Base-X receive path, bound to its top module.
module pcs_rx_sva #(
    parameter int HOLD_CYCLES  = 2000,
    parameter int READY_CYCLES = 50
) (
    // Clock, reset and inputs.
    input wire logic       ref_clk_i,
    input wire logic       nrst_i,
    input wire logic       rx_line_i,
    input wire logic       signal_detect_i,
    input wire logic       repeater_mode_i,
    input wire logic       tx_active_i,
    input wire logic       an_enable_i,
    input wire logic       an_link_ok_i,
    input wire logic       speed100_i,
    input wire logic       link10_i,
    input wire logic       mii_ready_i,
    // Outputs under watch.
    input wire logic [3:0] rxd_o,
    input wire logic       rx_dv_o,
    input wire logic       rx_er_o,
    input wire logic       crs_o,
    input wire logic       link_up_o,
    input wire logic       link_status_o,
    input wire logic       link_activity_output_o,
    input wire logic       scr_locked_o,
    input wire logic       rx_fifo_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks run on the receive clock; all but reset_state_a pause in reset.
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Start of a valid run, and a falling edge of signal energy.
    sequence dv_start;
        $rose(rx_dv_o);
    endsequence
    sequence sig_lost;
        signal_detect_i ##1 !signal_detect_i;
    endsequence

    // Reset holds the receive state quiet.
    reset_state_a: assert property (disable iff (1'b0) !nrst_i |->
        !rx_dv_o && !rx_er_o && !scr_locked_o && !link_up_o)
        else $error("receive outputs active during reset");
    dv_in_crs_a: assert property (rx_dv_o |-> crs_o)
        else $error("valid seen outside carrier");
    sof_preamble_a: assert property (dv_start |->
        rxd_o == pcs_rx_pkg::NIB_PREAMBLE ##1 rx_dv_o [*8])
        else $error("valid run does not open with a standing preamble nibble");
    link_mux_a: assert property (
        link_status_o == (speed100_i ? link_up_o : link10_i))
        else $error("link status does not follow the speed selection");
    activity_copy_a: assert property (link_activity_output_o == link_status_o)
        else $error("activity output differs from link status");
    crs_switch_a: assert property (!repeater_mode_i && tx_active_i |-> crs_o)
        else $error("carrier missing while transmitting in switch mode");
    bad_ssd_nib_a: assert property (
        rx_er_o && !rx_dv_o |-> rxd_o == pcs_rx_pkg::NIB_BAD_SSD)
        else $error("false carrier nibble is wrong");
    sig_loss_a: assert property (sig_lost |-> ##[1:20] !rx_dv_o && !link_up_o)
        else $error("valid or link stays up after signal loss");
    lock_link_a: assert property ($fell(scr_locked_o) |-> ##[0:2] !link_up_o)
        else $error("link stays up without descrambler lock");
endmodule

bind fast_ethernet_pcs_receiver pcs_rx_sva #(
    .HOLD_CYCLES (HOLD_CYCLES),
    .READY_CYCLES(READY_CYCLES)
) chk_u (.*);

// [verif/mii_mac_model.sv]
// Behavioural MAC that drains the MII receive bus and records beats.
module mii_mac_model (
    // Clock and reset.
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    // Bench control and MII.
    input  wire logic       stall_i,
    input  wire logic [3:0] rxd_i,
    input  wire logic       rx_dv_i,
    input  wire logic       rx_er_i,
    output logic            mii_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    pcs_rx_pkg::mii_beat_t beats[$];
    int unsigned           cnt;

    // Sample mid-period and move ready only there, so a period is wholly ready or stalled.
    always @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            mii_ready_o <= 1'b1;
        end else begin
            cnt <= (cnt == 9) ? 0 : cnt + 1;
            if (cnt == 5) begin
                if (mii_ready_o && (rx_dv_i || rx_er_i)) begin
                    beats.push_back({rx_dv_i, rx_er_i, rxd_i});
                end
                mii_ready_o <= !stall_i;
            end
        end
    end
endmodule

// [verif/fast_ethernet_pcs_receiver_tb.sv]
// Self-checking bench for the 100Base-X receive path.
module fast_ethernet_pcs_receiver_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
        5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic ref_clk_i, nrst_i, rx_line_i, signal_detect_i, repeater_mode_i;
    logic tx_active_i, an_enable_i, an_link_ok_i, speed100_i, link10_i;
    logic mii_ready_i, rx_dv_o, rx_er_o, crs_o, link_up_o, link_status_o;
    logic link_activity_output_o, scr_locked_o, rx_fifo_ready_o, stall, full_seen;
    logic [3:0]            rxd_o;
    logic [10:0]           scr;
    pcs_rx_pkg::mii_beat_t exp_q[$];
    int                    error_cnt, tests_run, k;

    // Clock at 4 ns period.
    initial begin
        ref_clk_i = 0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    fast_ethernet_pcs_receiver #(.HOLD_CYCLES(2000), .READY_CYCLES(50)) dut_u (.*);
    mii_mac_model mac_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .stall_i(stall),
        .rxd_i(rxd_o), .rx_dv_i(rx_dv_o), .rx_er_i(rx_er_o), .mii_ready_o(mii_ready_i));

    // Note when the nibble buffer refuses.
    always @(posedge ref_clk_i) begin
        if (nrst_i && !rx_fifo_ready_o) full_seen <= 1'b1;
    end

    function automatic logic [4:0] enc(logic [3:0] d);
        return ENC[d];
    endfunction

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Scramble one plain bit, NRZI-code it and hold it for one bit time.
    task automatic bitx(logic b);
        logic key;
        key = scr[10] ^ scr[8];
        scr = {scr[9:0], key};
        if (b ^ key) rx_line_i = ~rx_line_i;
        repeat (2) @(negedge ref_clk_i);
    endtask

    task automatic idle(int n);
        repeat (n) bitx(1'b1);
    endtask

    // First line bit is the code group MSB.
    task automatic sym(logic [4:0] s);
        for (int i = 4; i >= 0; i--) bitx(s[i]);
    endtask

    task automatic frame(int n, bit bad);
        logic [3:0] d;
        idle(20 + $urandom % 5);
        sym(5'h18);
        sym(5'h11);
        repeat (2) exp_q.push_back({2'b10, pcs_rx_pkg::NIB_PREAMBLE});
        repeat (n) begin
            d = $urandom;
            sym(enc(d));
            exp_q.push_back({2'b10, d});
        end
        if (bad) sym(5'h00);
        if (bad) exp_q.push_back({2'b11, 4'h0});
        sym(pcs_rx_pkg::SYM_T);
        sym(pcs_rx_pkg::SYM_R);
        idle(40);
    endtask

    task automatic compare(bit part);
        pcs_rx_pkg::mii_beat_t e;
        int n;
        n = part ? 16 : exp_q.size();
        if (!part) check("count", mac_u.beats.size(), exp_q.size());
        for (int i = 0; i < n; i++) begin
            e = exp_q[i];
            if (e.er) check("rx_er", mac_u.beats[i].er, 1);
            else check("beat", mac_u.beats[i], e);
        end
        check("crs_o", crs_o, !repeater_mode_i && tx_active_i);
        exp_q.delete();
        mac_u.beats.delete();
    endtask

    task automatic bring_up();
        signal_detect_i = 1;
        idle(60);
        check("scr_locked_o", scr_locked_o, 1);
        idle(50);
        check("link_up_o", link_up_o, !an_enable_i);
        an_link_ok_i = 1;
        idle(5);
        check("link_up_o", link_up_o, 1);
    endtask

    task automatic report_and_stop();
        $display("errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 35 us.
    initial begin
        #150000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        {nrst_i, rx_line_i, signal_detect_i, repeater_mode_i, tx_active_i} = 5'h10;
        {an_enable_i, an_link_ok_i, speed100_i, link10_i, stall, full_seen} = 6'h20;
        error_cnt = 0;
        tests_run = 0;
        scr = 11'h5A3;
        void'($urandom(37));
        // Reset falls just after time zero so every flop sees its edge.
        #1 nrst_i = 0;
        for (k = 0; k < 4; k++) begin
            {repeater_mode_i, tx_active_i} = k;
            {speed100_i, link10_i} = k;
            #1;
            check("crs_o", crs_o, k == 1);
            check("link_status_o", link_status_o, k == 1);
        end
        {repeater_mode_i, tx_active_i, speed100_i, link10_i} = 4'hA;
        repeat (3) @(negedge ref_clk_i);
        nrst_i = 1;
        check("rx_dv_o", rx_dv_o, 0);
        check("rx_fifo_ready_o", rx_fifo_ready_o, 1);
        bring_up();
        check("link_status_o", link_status_o, 1);
        check("link_activity_output_o", link_activity_output_o, 1);
        for (k = 0; k < 5; k++) begin
            {repeater_mode_i, tx_active_i} = $urandom;
            frame(1 + $urandom % 12, k == 3);
            compare(0);
        end
        {repeater_mode_i, stall} = 2'b11;
        frame(30, 0);
        stall = 0;
        idle(300);
        compare(1);
        check("full_seen", full_seen, 1);
        check("rx_fifo_ready_o", rx_fifo_ready_o, 1);
        idle(20);
        repeat (4) sym(5'h0F);
        idle(40);
        check("bad count", mac_u.beats.size() > 0, 1);
        foreach (mac_u.beats[i]) check("bad beat", mac_u.beats[i], 6'h1E);
        check("crs_o", crs_o, 0);
        check("rx_er_o", rx_er_o, 0);
        mac_u.beats.delete();
        idle(20);
        sym(5'h18);
        sym(5'h11);
        repeat (4) sym(enc(4'h3));
        signal_detect_i = 0;
        idle(10);
        check("rx_dv_o", rx_dv_o, 0);
        check("link_up_o", link_up_o, 0);
        mac_u.beats.delete();
        an_enable_i = 0;
        bring_up();
        idle(40);
        repeat (180) sym(5'h1E);
        check("scr_locked_o", scr_locked_o, 1);
        repeat (60) sym(5'h1E);
        check("scr_locked_o", scr_locked_o, 0);
        check("link_up_o", link_up_o, 0);
        mac_u.beats.delete();
        bring_up();
        idle(1500);
        check("scr_locked_o", scr_locked_o, 1);
        report_and_stop();
    end
endmodule
